// ---- verilog/eca_cfg.svh ----
// eca_cfg.svh: cost constants for the execution cycle accounting block
// assumes inclusion by bare name from the package and the design modules
// Function
// - scaled index base uses base mode cost, except register and stack top
// - register base mode costs five cycles
// - stack top base mode costs four
// - index scale cost 5, 7, 8, 10
// - word transfer zero or 4*bus_cycle_count-1
// - dword transfer zero or 4*bus_cycle_count-1
// - length transfer picks byte, word or dword
// - length multiplier 1, 2 or 4
// - float size factor 1 or 2
// - float xfer 4, integer xfer 2 or 4
// - split entry flushes queue then refetches
// - single refetch cycle adds six plus fetch
// - multiple refetch cycles add five plus fetch
// - immediate costs same internal as register
// - address flag one adds address cost
// - overlap is max of parallel, coproc+3
`ifndef ECA_CFG_SVH
`define ECA_CFG_SVH
`define ECA_CW 12
`define ECA_EA_IMM_ABS 12'h004
`define ECA_EA_REG 12'h002
`define ECA_EA_REG_REL 12'h005
`define ECA_EA_MEM_REL 12'h007
`define ECA_EA_EXT 12'h00b
`define ECA_EA_TOS_WR 12'h004
`define ECA_EA_TOS_RD 12'h002
`define ECA_EA_TOS_RMW 12'h003
`define ECA_TI1_REG 12'h005
`define ECA_TI1_TOS 12'h004
`define ECA_TI2_B 12'h005
`define ECA_TI2_W 12'h007
`define ECA_TI2_D 12'h008
`define ECA_TI2_Q 12'h00a
`define ECA_BYTE_XFER 12'h003
`define ECA_XFER_MUL 12'h004
`define ECA_XFER_SUB 12'h001
`define ECA_LEN_B 12'h001
`define ECA_LEN_W 12'h002
`define ECA_LEN_D 12'h004
`define ECA_FSZ_STD 12'h001
`define ECA_FSZ_LONG 12'h002
`define ECA_TF 12'h004
`define ECA_TI_BW 12'h002
`define ECA_TI_D 12'h004
`define ECA_FLUSH_ONE 12'h006
`define ECA_FLUSH_MANY 12'h005
`define ECA_FPU_ADD 12'h003
`endif

// ---- verilog/eca_pkg.sv ----
// eca_pkg.sv: types shared by the cycle accounting modules
// assumes eca_cfg.svh is on the include path
`include "eca_cfg.svh"
package eca_pkg;
  typedef logic [`ECA_CW-1:0] eca_cyc_t;
  // addressing modes of one operand
  typedef enum logic [3:0] {
    ECA_M_REG = 4'h0,
    ECA_M_IMM = 4'h1,
    ECA_M_ABS = 4'h2,
    ECA_M_REL = 4'h3,
    ECA_M_MSP = 4'h4,
    ECA_M_MREL = 4'h5,
    ECA_M_EXT = 4'h6,
    ECA_M_TOS = 4'h7
  } eca_mode_t;
  typedef enum logic [1:0] {ECA_AC_RD = 2'h0, ECA_AC_WR = 2'h1, ECA_AC_RMW = 2'h2} eca_acc_t;
  typedef enum logic [1:0] {ECA_L_B = 2'h0, ECA_L_W = 2'h1, ECA_L_D = 2'h2, ECA_L_Q = 2'h3} eca_len_t;
  // one operand description
  typedef struct packed {
    logic ea_flag;
    eca_mode_t mode;
    logic scaled;
    eca_len_t scale;
    eca_acc_t acc;
    logic [3:0] bus_cycle_count;
    logic [3:0] bus_cycle_count_ind;
    logic [3:0] bus_cycle_count_ext0;
    logic [3:0] bus_cycle_count_ext1;
  } eca_opnd_t;
  // one instruction request
  typedef struct packed {
    eca_opnd_t op1;
    eca_opnd_t op2;
    eca_len_t len;
    logic [3:0] n_len_xfer_cycles;
    logic [3:0] n_byte_xfer_cycles;
    logic [3:0] n_word_xfer_cycles;
    logic [3:0] n_dword_xfer_cycles;
    logic [3:0] n_l;
    eca_cyc_t tcy_n1;
    eca_cyc_t tcy_n2;
    logic split;
    logic fetch_one;
    eca_cyc_t t_fetch;
    logic is_float;
    logic fsz_long;
    logic [3:0] n_tf;
    logic [3:0] n_ti;
    eca_cyc_t parallel_core_cycles;
    eca_cyc_t coproc_exec_cycles;
  } eca_req_t;
endpackage

// ---- verilog/eca_ea_cost.sv ----
// eca_ea_cost.sv: effective address cost of one operand, registered
// assumes synchronous inputs and the released reset of the top
`timescale 1ns/1ps
`default_nettype none
`include "eca_cfg.svh"
module eca_ea_cost
  import eca_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // operand in, cost out
  input wire eca_opnd_t opnd_in,
  output logic [`ECA_CW-1:0] cost_out
);
  // transfer cost of a memory dword by bus cycle count
  function automatic eca_cyc_t xfer(input logic [3:0] n);
    xfer = `ECA_XFER_MUL * {8'h00, n} - `ECA_XFER_SUB;
  endfunction
  // base mode cost
  function automatic eca_cyc_t base_cost(input eca_opnd_t o);
    unique case (o.mode)
      ECA_M_IMM, ECA_M_ABS: base_cost = `ECA_EA_IMM_ABS;
      ECA_M_REG: base_cost = `ECA_EA_REG;
      ECA_M_REL, ECA_M_MSP: base_cost = `ECA_EA_REG_REL;
      ECA_M_MREL: base_cost = `ECA_EA_MEM_REL + xfer(o.bus_cycle_count_ind);
      ECA_M_EXT: base_cost = `ECA_EA_EXT + xfer(o.bus_cycle_count_ext0) + xfer(o.bus_cycle_count_ext1);
      ECA_M_TOS:
        unique case (o.acc)
          ECA_AC_WR: base_cost = `ECA_EA_TOS_WR;
          ECA_AC_RMW: base_cost = `ECA_EA_TOS_RMW;
          default: base_cost = `ECA_EA_TOS_RD;
        endcase
      default: base_cost = `ECA_EA_REG;
    endcase
  endfunction
  eca_cyc_t ti1, ti2, cost_nxt;
  // scaled index splits into base part and scale part
  always_comb
  begin
    unique case (opnd_in.mode)
      ECA_M_REG: ti1 = `ECA_TI1_REG;
      ECA_M_TOS: ti1 = `ECA_TI1_TOS;
      default: ti1 = base_cost(opnd_in);
    endcase
    unique case (opnd_in.scale)
      ECA_L_B: ti2 = `ECA_TI2_B;
      ECA_L_W: ti2 = `ECA_TI2_W;
      ECA_L_D: ti2 = `ECA_TI2_D;
      default: ti2 = `ECA_TI2_Q;
    endcase
    if (!opnd_in.ea_flag)
      cost_nxt = '0;
    else if (opnd_in.scaled)
      cost_nxt = ti1 + ti2;
    else
      cost_nxt = base_cost(opnd_in);
  end
  // registered cost
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      cost_out <= '0;
    else if (ce_in)
      cost_out <= cost_nxt;
  end
endmodule // eca_ea_cost
`default_nettype wire

// ---- verilog/eca_xfer.sv ----
// eca_xfer.sv: memory operand transfer costs for one operand
// assumes synchronous inputs and the released reset of the top
`timescale 1ns/1ps
`default_nettype none
`include "eca_cfg.svh"
module eca_xfer
  import eca_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // operand and length
  input wire eca_opnd_t opnd_in,
  input wire eca_len_t len_in,
  // costs
  output logic [`ECA_CW-1:0] byte_out,
  output logic [`ECA_CW-1:0] word_out,
  output logic [`ECA_CW-1:0] dword_out,
  output logic [`ECA_CW-1:0] len_out
);
  eca_cyc_t b_nxt, w_nxt, i_nxt;
  logic in_reg;
  // register or immediate operands cost no transfer
  always_comb
  begin
    in_reg = (opnd_in.mode == ECA_M_REG) || (opnd_in.mode == ECA_M_IMM);
    b_nxt = in_reg ? '0 : `ECA_BYTE_XFER;
    w_nxt = in_reg ? '0 : `ECA_XFER_MUL * {8'h00, opnd_in.bus_cycle_count} - `ECA_XFER_SUB;
    unique case (len_in)
      ECA_L_B: i_nxt = b_nxt;
      ECA_L_W: i_nxt = w_nxt;
      default: i_nxt = w_nxt;
    endcase
  end
  // registered costs, word and dword share one formula
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      byte_out <= '0;
      word_out <= '0;
      dword_out <= '0;
      len_out <= '0;
    end
    else if (ce_in)
    begin
      byte_out <= b_nxt;
      word_out <= w_nxt;
      dword_out <= w_nxt;
      len_out <= i_nxt;
    end
  end
endmodule // eca_xfer
`default_nettype wire

// ---- verilog/eca_top.sv ----
// eca_top.sv: instruction execution cycle accounting engine
// assumes one synchronous request per valid pulse; result two cycles later
`timescale 1ns/1ps
`default_nettype none
`include "eca_cfg.svh"
module eca_top
  import eca_pkg::*;
(
  // clock, reset, enable
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // request
  input wire logic valid_in,
  input wire eca_req_t req_in,
  // result
  output logic done_out,
  output logic [`ECA_CW-1:0] addr_calc_cycles_out,
  output logic [`ECA_CW-1:0] len_xfer_cycles_out,
  output logic [`ECA_CW-1:0] internal_cycles_out,
  output logic [`ECA_CW-1:0] total_exec_cycles_out
);
  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_s1_r, rst_s2_r;
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire logic rst_n;
  assign rst_n = rst_s2_r;
  ////////////////////////////////////////////////////////////////////////////
  // operand cost units, one cycle latency
  eca_cyc_t ea1, ea2, b1, b2, w1, w2, d1, d2, i1, i2;
  eca_ea_cost u_ea1 (.clock_in(clock_in), .rst_n_in(rst_n), .ce_in(ce_in),
    .opnd_in(req_in.op1), .cost_out(ea1));
  eca_ea_cost u_ea2 (.clock_in(clock_in), .rst_n_in(rst_n), .ce_in(ce_in),
    .opnd_in(req_in.op2), .cost_out(ea2));
  eca_xfer u_x1 (.clock_in(clock_in), .rst_n_in(rst_n), .ce_in(ce_in),
    .opnd_in(req_in.op1), .len_in(req_in.len), .byte_out(b1), .word_out(w1),
    .dword_out(d1), .len_out(i1));
  eca_xfer u_x2 (.clock_in(clock_in), .rst_n_in(rst_n), .ce_in(ce_in),
    .opnd_in(req_in.op2), .len_in(req_in.len), .byte_out(b2), .word_out(w2),
    .dword_out(d2), .len_out(i2));
  ////////////////////////////////////////////////////////////////////////////
  // small multiply used for per-count terms
  function automatic eca_cyc_t mul4(input logic [3:0] n, input eca_cyc_t v);
    mul4 = eca_cyc_t'({8'h00, n} * v);
  endfunction
  // stage one registers the per-instruction factors
  logic v1_r;
  eca_cyc_t lmul_r, fmul_r, ti_r, tcy_r, tpr_r, coproc_exec_cycles_r;
  eca_req_t q_r;
  eca_cyc_t lmul_nxt, fmul_nxt, ti_nxt, tcy_nxt;
  always_comb
  begin
    unique case (req_in.len)
      ECA_L_B: lmul_nxt = `ECA_LEN_B;
      ECA_L_W: lmul_nxt = `ECA_LEN_W;
      default: lmul_nxt = `ECA_LEN_D;
    endcase
    fmul_nxt = req_in.fsz_long ? `ECA_FSZ_LONG : `ECA_FSZ_STD;
    ti_nxt = (req_in.len == ECA_L_D) ? `ECA_TI_D : `ECA_TI_BW;
    // immediate operands get the register row of the table upstream
    if (req_in.split)
      tcy_nxt = req_in.tcy_n1 + req_in.t_fetch
        + (req_in.fetch_one ? `ECA_FLUSH_ONE : `ECA_FLUSH_MANY);
    else
      tcy_nxt = req_in.tcy_n1;
  end
  // stage one flops
  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      v1_r <= 1'b0;
      lmul_r <= '0;
      fmul_r <= '0;
      ti_r <= '0;
      tcy_r <= '0;
      tpr_r <= '0;
      coproc_exec_cycles_r <= '0;
      q_r <= '0;
    end
    else if (ce_in)
    begin
      v1_r <= valid_in;
      lmul_r <= lmul_nxt;
      fmul_r <= fmul_nxt;
      ti_r <= ti_nxt;
      tcy_r <= tcy_nxt;
      tpr_r <= req_in.parallel_core_cycles;
      coproc_exec_cycles_r <= req_in.coproc_exec_cycles;
      q_r <= req_in;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // stage two sums the terms
  eca_cyc_t ea_sum, xfer_sum, ovl, tot_nxt, int_nxt;
  always_comb
  begin
    ea_sum = ea1 + ea2;
    xfer_sum = mul4(q_r.n_len_xfer_cycles, i1 + i2) + mul4(q_r.n_byte_xfer_cycles, b1 + b2)
      + mul4(q_r.n_word_xfer_cycles, w1 + w2) + mul4(q_r.n_dword_xfer_cycles, d1 + d2);
    int_nxt = tcy_r + mul4(q_r.n_l, lmul_r);
    if (q_r.is_float)
    begin
      ovl = (tpr_r > coproc_exec_cycles_r + `ECA_FPU_ADD) ? tpr_r : coproc_exec_cycles_r + `ECA_FPU_ADD;
      xfer_sum = xfer_sum + mul4(q_r.n_tf, fmul_r * `ECA_TF) + mul4(q_r.n_ti, ti_r);
    end
    else
      ovl = '0;
    tot_nxt = ea_sum + xfer_sum + int_nxt + ovl;
  end
  // result flops
  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      done_out <= 1'b0;
      addr_calc_cycles_out <= '0;
      len_xfer_cycles_out <= '0;
      internal_cycles_out <= '0;
      total_exec_cycles_out <= '0;
    end
    else if (ce_in)
    begin
      done_out <= v1_r;
      addr_calc_cycles_out <= ea_sum;
      len_xfer_cycles_out <= xfer_sum;
      internal_cycles_out <= int_nxt;
      total_exec_cycles_out <= tot_nxt;
    end
  end
endmodule // eca_top
`default_nettype wire

// ---- dv/eca_top_assertions.sv ----
// eca_top_assertions.sv: port checks for the cycle accounting engine
// assumes ce_in stays high around the requests it judges
`timescale 1ns/1ps
`default_nettype none
`include "eca_cfg.svh"
module eca_top_assertions
  import eca_pkg::*;
(
  // clock, reset, enable
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // request
  input wire logic valid_in,
  input wire eca_req_t req_in,
  // result
  input wire logic done_out,
  input wire logic [`ECA_CW-1:0] addr_calc_cycles_out,
  input wire logic [`ECA_CW-1:0] len_xfer_cycles_out,
  input wire logic [`ECA_CW-1:0] internal_cycles_out,
  input wire logic [`ECA_CW-1:0] total_exec_cycles_out
);
  eca_req_t rq_r;
  logic [`ECA_CW-1:0] ovl_nxt;
  // request belonging to the answer that is visible now: taken two edges before
  always_ff @(posedge clock_in) rq_r <= $past(req_in, 1);
  // overlap term, only for float requests
  assign ovl_nxt = !rq_r.is_float ? 12'h000 :
    (rq_r.parallel_core_cycles > rq_r.coproc_exec_cycles + 12'h003) ? rq_r.parallel_core_cycles : rq_r.coproc_exec_cycles + 12'h003;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_go;
    valid_in && ce_in ##1 ce_in;
  endsequence
  property p_cost(c, e);
    s_go ##1 c |-> e;
  endproperty
  ////////////////////////////////////////////////////////////
  done_lat_a: assert property (s_go |=> done_out) else $error("answer late");
  ce_hold_a: assert property (!ce_in |=> $stable(done_out) && $stable(total_exec_cycles_out))
    else $error("output moved while disabled");
  rst_zero_a: assert property (disable iff (1'b0) !rst_n_in ##1 !rst_n_in |-> !done_out)
    else $error("done during reset");
  ea_none_a: assert property (p_cost(!rq_r.op1.ea_flag && !rq_r.op2.ea_flag,
    addr_calc_cycles_out == 12'h000)) else $error("absent operand cost");
  ea_reg_a: assert property (p_cost(rq_r.op1.ea_flag && rq_r.op1.mode == ECA_M_REG &&
    !rq_r.op1.scaled && !rq_r.op2.ea_flag, addr_calc_cycles_out == 12'h002))
    else $error("register cost");
  idx_regq_a: assert property (p_cost(rq_r.op1.ea_flag && rq_r.op1.scaled &&
    rq_r.op1.mode == ECA_M_REG && rq_r.op1.scale == ECA_L_Q && !rq_r.op2.ea_flag,
    addr_calc_cycles_out == 12'h00f)) else $error("scaled register cost");
  xfer_reg_a: assert property (p_cost(!rq_r.is_float && rq_r.op1.mode == ECA_M_REG &&
    rq_r.op2.mode == ECA_M_REG, len_xfer_cycles_out == 12'h000)) else $error("register xfer");
  len_word_a: assert property (p_cost(!rq_r.split && rq_r.len == ECA_L_W,
    internal_cycles_out == rq_r.tcy_n1 + 2 * rq_r.n_l)) else $error("word length term");
  flush_one_a: assert property (p_cost(rq_r.split && rq_r.fetch_one && rq_r.len == ECA_L_B,
    internal_cycles_out == rq_r.tcy_n1 + 12'h006 + rq_r.t_fetch + rq_r.n_l))
    else $error("single refetch cost");
  sum_ovl_a: assert property (p_cost(1'b1, total_exec_cycles_out == addr_calc_cycles_out +
    len_xfer_cycles_out + internal_cycles_out + ovl_nxt)) else $error("total mismatch");
endmodule // eca_top_assertions
bind eca_top eca_top_assertions chk_u (.clock_in, .rst_n_in, .ce_in, .valid_in, .req_in,
  .done_out, .addr_calc_cycles_out, .len_xfer_cycles_out, .internal_cycles_out,
  .total_exec_cycles_out);
`default_nettype wire

// ---- dv/eca_top_tb.sv ----
// eca_top_tb.sv: self-checking bench for the cycle accounting engine
// assumes the design files and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "eca_cfg.svh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %h seen %h", n, e, s); end end
module eca_top_tb
  import eca_pkg::*;
;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b1;
  logic ce_in = 1'b1;
  logic valid_in = 1'b0;
  eca_req_t req_in = '0;
  eca_req_t r;
  logic done_out;
  logic [`ECA_CW-1:0] ac, lx, ic, tx;
  logic [47:0] res_q[$];
  int num_errors = 0;
  int checks = 0;
  always #5 clock_in = ~clock_in;
  eca_top dut_u (.clock_in, .rst_n_in, .ce_in, .valid_in, .req_in, .done_out,
    .addr_calc_cycles_out(ac), .len_xfer_cycles_out(lx), .internal_cycles_out(ic),
    .total_exec_cycles_out(tx));
  // keep answers in order so pipelined requests are judged one by one
  always @(posedge clock_in)
    if (done_out === 1'b1) res_q.push_back({ac, lx, ic, tx});
  ////////////////////////////////////////////////////////////
  // valid stays up across back-to-back sends; stop lowers it once
  task automatic send(input eca_req_t q);
    req_in <= q;
    valid_in <= 1'b1;
    @(posedge clock_in);
  endtask
  task automatic stop;
    valid_in <= 1'b0;
  endtask
  // operand that needs an address; counts and access class start at zero
  function automatic eca_opnd_t mk_op(input eca_mode_t m, input logic sc, input eca_len_t s);
    eca_opnd_t o;
    o = '0;
    o.ea_flag = 1'b1;
    o.mode = m;
    o.scaled = sc;
    o.scale = s;
    return o;
  endfunction
  task automatic expect4(input string n, input logic [47:0] e);
    logic [47:0] s;
    repeat (20) if (res_q.size() == 0) @(posedge clock_in);
    s = res_q.size() ? res_q.pop_front() : 'x;
    `CHK(n, e, s)
  endtask
  task automatic t_basic;
    r = '0;
    r.op1.ea_flag = 1'b1;
    r.op2.ea_flag = 1'b1;
    r.op2.mode = ECA_M_TOS;
    r.op2.bus_cycle_count = 4'h1;
    r.len = ECA_L_W;
    r.n_len_xfer_cycles = 4'h1;
    r.tcy_n1 = 12'h003;
    send(r);
    r.op1.mode = ECA_M_IMM;
    send(r);
    r = '0;
    r.op1 = mk_op(ECA_M_MREL, 1'b0, ECA_L_B);
    r.op1.bus_cycle_count_ind = 4'h1;
    r.op1.bus_cycle_count = 4'h1;
    r.op2 = mk_op(ECA_M_EXT, 1'b0, ECA_L_B);
    r.op2.bus_cycle_count_ext0 = 4'h1;
    r.op2.bus_cycle_count_ext1 = 4'h2;
    r.op2.bus_cycle_count = 4'h2;
    r.n_len_xfer_cycles = 4'h1;
    r.n_byte_xfer_cycles = 4'h1;
    r.n_word_xfer_cycles = 4'h1;
    send(r);
    stop;
    expect4("reg tos", {12'h004, 12'h003, 12'h003, 12'h00a});
    expect4("imm tos", {12'h006, 12'h003, 12'h003, 12'h00c});
    expect4("mrel ext", {12'h01f, 12'h016, 12'h000, 12'h035});
    $display("test basic done");
  endtask
  task automatic t_scaled;
    r = '0;
    r.op1 = mk_op(ECA_M_REG, 1'b1, ECA_L_Q);
    r.op2 = mk_op(ECA_M_TOS, 1'b1, ECA_L_B);
    send(r);
    r.op1 = mk_op(ECA_M_ABS, 1'b1, ECA_L_W);
    r.op2.mode = ECA_M_REG;
    r.op2.scale = ECA_L_D;
    send(r);
    r.op1 = mk_op(ECA_M_REG, 1'b1, ECA_L_Q);
    r.op2 = '0;
    send(r);
    r.op1 = mk_op(ECA_M_REL, 1'b0, ECA_L_B);
    r.op2 = mk_op(ECA_M_TOS, 1'b0, ECA_L_B);
    r.op2.acc = ECA_AC_WR;
    send(r);
    r.op1.mode = ECA_M_MSP;
    r.op2.acc = ECA_AC_RMW;
    send(r);
    stop;
    expect4("idx reg tos", {12'h018, 24'h0, 12'h018});
    expect4("idx abs reg", {12'h018, 24'h0, 12'h018});
    expect4("idx reg only", {12'h00f, 24'h0, 12'h00f});
    expect4("rel tos wr", {12'h009, 24'h0, 12'h009});
    expect4("msp tos rmw", {12'h008, 24'h0, 12'h008});
    $display("test scaled done");
  endtask
  task automatic t_split;
    r = '0;
    r.split = 1'b1;
    r.fetch_one = 1'b1;
    r.tcy_n1 = 12'h00f;
    r.t_fetch = 12'h003;
    r.n_l = 4'h2;
    send(r);
    r.fetch_one = 1'b0;
    r.len = ECA_L_D;
    send(r);
    r = '0;
    r.op1.ea_flag = 1'b1;
    r.tcy_n1 = 12'h009;
    r.tcy_n2 = 12'h014;
    r.len = ECA_L_W;
    r.n_l = 4'h1;
    send(r);
    stop;
    expect4("flush one", {24'h0, 12'h01a, 12'h01a});
    expect4("flush many", {24'h0, 12'h01f, 12'h01f});
    expect4("no flush", {12'h002, 12'h000, 12'h00b, 12'h00d});
    $display("test split done");
  endtask
  task automatic t_float;
    r = '0;
    r.op2 = mk_op(ECA_M_ABS, 1'b0, ECA_L_B);
    r.op2.bus_cycle_count = 4'h2;
    r.n_dword_xfer_cycles = 4'h1;
    r.is_float = 1'b1;
    r.fsz_long = 1'b1;
    r.n_tf = 4'h1;
    r.tcy_n1 = 12'h020;
    r.parallel_core_cycles = 12'h00a;
    r.coproc_exec_cycles = 12'h013;
    send(r);
    r = '0;
    r.is_float = 1'b1;
    r.n_tf = 4'h3;
    r.n_ti = 4'h1;
    r.len = ECA_L_D;
    r.parallel_core_cycles = 12'h028;
    r.coproc_exec_cycles = 12'h013;
    send(r);
    stop;
    expect4("float long", {12'h004, 12'h00f, 12'h020, 12'h049});
    expect4("float std", {12'h000, 12'h010, 12'h000, 12'h038});
    $display("test float done");
  endtask
  task automatic t_freeze;
    r = '0;
    r.op1 = mk_op(ECA_M_REG, 1'b1, ECA_L_Q);
    r.tcy_n1 = 12'h003;
    send(r);
    stop;
    ce_in <= 1'b0;
    repeat (4) @(posedge clock_in);
    `CHK("held", 0, res_q.size())
    ce_in <= 1'b1;
    expect4("after hold", {12'h00f, 12'h000, 12'h003, 12'h012});
    $display("test freeze done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // reset, then the scenarios in turn
  initial
  begin
    rst_n_in <= 1'b0;
    repeat (12) @(posedge clock_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    t_basic;
    t_scaled;
    t_split;
    t_float;
    t_freeze;
    print_verdict;
  end
  // watchdog at 2000 cycles, well past the fewer than one hundred cycles the tests need
  initial
  begin
    #20000;
    num_errors++;
    print_verdict;
  end
endmodule // eca_top_tb
`default_nettype wire
